// ==== air_defines.vh ====
/*
  constants for the analog input function router: register offsets,
  field positions, reset values and function codes.
  assumes inclusion by bare name from the router module.
*/
`ifndef AIR_DEFINES_VH
`define AIR_DEFINES_VH

// register byte offsets (apb, one aligned word each)
`define AIR_OFS_ENABLE_MASK 12'h000
`define AIR_OFS_CH1_OFFSET 12'h004
`define AIR_OFS_CH2_OFFSET 12'h008
`define AIR_OFS_CH3_OFFSET 12'h00c
`define AIR_OFS_FUNC_CODES 12'h010
`define AIR_OFS_CONTROL 12'h014
`define AIR_OFS_GAIN_BASE 12'h018
`define AIR_OFS_BIAS_BASE 12'h024
`define AIR_OFS_STATUS 12'h030
`define AIR_OFS_LEVEL_BASE 12'h034

// reset values
`define AIR_RST_ENABLE_MASK 3'h7
`define AIR_RST_OFFSET 16'h0000
`define AIR_RST_FUNC_CH1 6'h00
`define AIR_RST_FUNC_CH2 6'h00
`define AIR_RST_FUNC_CH3 6'h02
`define AIR_RST_GAIN 16'h03e8
`define AIR_RST_BIAS 16'h0000

// offset range limits, signed counts
`define AIR_OFFSET_MAX 16'sd500
`define AIR_OFFSET_MIN -16'sd500

// control register fields
`define AIR_CTL_PI_EN 0
`define AIR_CTL_VF_MODE 1
`define AIR_CTL_REF_ANALOG 2

// function codes
`define AIR_FN_FREQ_BIAS 6'h00
`define AIR_FN_FREQ_GAIN 6'h01
`define AIR_FN_AUX_REF1 6'h02
`define AIR_FN_AUX_REF2 6'h03
`define AIR_FN_VOLT_BIAS 6'h04
`define AIR_FN_RAMP_GAIN 6'h05
`define AIR_FN_DC_BRAKE 6'h06
`define AIR_FN_TORQUE_LVL 6'h07
`define AIR_FN_STALL_LVL 6'h08
`define AIR_FN_FREQ_LOWER 6'h09
`define AIR_FN_PI_FEEDBACK 6'h0b
`define AIR_FN_PI_SETPOINT 6'h0c
`define AIR_FN_FREQ_BIAS_ANY 6'h0d
`define AIR_FN_MOTOR_TEMP 6'h0e
`define AIR_FN_THROUGH 6'h0f
`define AIR_FN_PI_DIFF 6'h16
`define AIR_FN_NTC 6'h17
`define AIR_FN_THROUGH2 6'h1f
`define AIR_FN_USER1 6'h30
`define AIR_FN_USER3 6'h32

// full scale (100.0 %) in tenths of a percent
`define AIR_FULL_SCALE 1000

`endif

// ==== air_router.v ====
/*
  analog input function router: three conditioned channels, each scaled by
  gain and bias plus a zero offset, gated by an enable mask and routed to
  control functions by a per-channel function code. registers over apb.
  assumes channel samples are already converted and filtered, synchronous
  to sys_clk_i, in tenths of a percent of full scale (1000 = 10 Vdc).
*/
// Local design decisions: the address map and the APB register port.
// Functional notes
// - analog-enable input closed: only mask-selected channels stay enabled
// - no input assigned analog-enable: all three channels always enabled
// - enable selection 1..7, default 7; bit weights 1,2,4 pick channels 1,2,3
// - signed per-channel zero offset -500..500, default 0
// - accept codes 0-9,B-F,16,17,1F,30-32; route scaled value per code
// - code 0 adds to analog reference; ignored for non-analog source
// - several code-0 channels all sum into the reference
// - code 1 multiplies analog reference by the channel percentage
// - codes 2,3 give auxiliary references one and two
// - code 4 boosts voltage by percent of max, only under v/f
// - code 5 scales accel/decel times by the channel gain
// - code 6 sets dc braking current as percent of max current
// - code 7 replaces torque detect level; 100% input equals 100% rated
// - code 8 stall level is lower of programmed and channel value
// - code 9 sets output frequency lower limit
// - code B gives pi feedback, only with pi enabled
// - code C gives pi setpoint replacing reference source, pi enabled
// - code D adds to the reference from any source
// - code E motor temperature thermistor input, third channel only
// - codes F,1F drive nothing but level stays readable
// - code 16 subtracts differential channel from pi feedback
// - linear scaling: gain at 10 Vdc, bias at zero input
`timescale 1ns/1ps
`include "air_defines.vh"

module air_router #(
  parameter DW = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  // channel samples, tenths of a percent
  input wire signed [DW-1:0] first_analog_channel_i,
  input wire signed [DW-1:0] second_analog_channel_i,
  input wire signed [DW-1:0] third_analog_channel_i,
  input wire analog_enable_assigned_i,
  input wire analog_enable_closed_i,
  // downstream references and programmed levels
  input wire signed [DW-1:0] analog_freq_ref_i,
  input wire signed [DW-1:0] freq_ref_i,
  input wire signed [DW-1:0] running_stall_level_i,
  input wire signed [DW-1:0] torque_detect_level_i,
  input wire [DW-1:0] ramp_time_settings_i,
  // routed functions
  output reg signed [DW-1:0] freq_ref_o,
  output reg signed [DW-1:0] aux_ref1_o,
  output reg aux_ref1_valid_o,
  output reg signed [DW-1:0] aux_ref2_o,
  output reg aux_ref2_valid_o,
  output reg signed [DW-1:0] volt_bias_o,
  output reg [DW-1:0] ramp_time_o,
  output reg signed [DW-1:0] dc_brake_level_o,
  output reg dc_brake_valid_o,
  output reg signed [DW-1:0] torque_detect_level_o,
  output reg signed [DW-1:0] stall_level_o,
  output reg signed [DW-1:0] freq_lower_o,
  output reg freq_lower_valid_o,
  output reg signed [DW-1:0] pi_feedback_o,
  output reg pi_feedback_valid_o,
  output reg signed [DW-1:0] pi_setpoint_o,
  output reg pi_setpoint_valid_o,
  output reg signed [DW-1:0] motor_temp_o,
  output reg motor_temp_valid_o
);

  // full scale held at the datapath width so products and quotients stay 48 bits
  localparam signed [47:0] FS = `AIR_FULL_SCALE;

  // clamp a wide value into the signed channel width
  function signed [DW-1:0] sat;
    input signed [47:0] v;
    reg signed [47:0] hi;
    reg signed [47:0] lo;
    begin
      hi = (48'sd1 <<< (DW-1)) - 48'sd1;
      lo = -(48'sd1 <<< (DW-1));
      if (v > hi)
        sat = hi[DW-1:0];
      else if (v < lo)
        sat = lo[DW-1:0];
      else
        sat = v[DW-1:0];
    end
  endfunction

  // accepted function codes; anything else behaves like pass-through
  function known_code;
    input [5:0] c;
    begin
      case (c)
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
        6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h16, 6'h17, 6'h1f,
        6'h30, 6'h31, 6'h32: known_code = 1'b1;
        default: known_code = 1'b0;
      endcase
    end
  endfunction

  // clamp a write into the offset range
  function [15:0] clamp_offset;
    input [15:0] w;
    begin
      if ($signed(w) > `AIR_OFFSET_MAX)
        clamp_offset = `AIR_OFFSET_MAX;
      else if ($signed(w) < `AIR_OFFSET_MIN)
        clamp_offset = `AIR_OFFSET_MIN;
      else
        clamp_offset = w;
    end
  endfunction

  reg [2:0] enable_mask_reg;
  reg [15:0] offset_reg [0:2];
  reg [5:0] func_reg [0:2];
  reg [15:0] gain_reg [0:2];
  reg [15:0] bias_reg [0:2];
  reg [2:0] ctl_reg;
  reg signed [DW-1:0] level_reg [0:2];
  reg [2:0] chan_en_reg;

  wire signed [DW-1:0] raw [0:2];
  assign raw[0] = first_analog_channel_i;
  assign raw[1] = second_analog_channel_i;
  assign raw[2] = third_analog_channel_i;

  wire apb_setup = psel_i & ~penable_i;
  wire apb_wr = psel_i & penable_i & pwrite_i & pready_o;
  wire [3:0] widx = paddr_i[5:2];
  wire addr_ok = (paddr_i[1:0] == 2'b00) && (paddr_i <= `AIR_OFS_LEVEL_BASE + 12'h008);

  // linear scaling per channel: bias + gain*x/fs, plus zero offset
  reg signed [DW-1:0] scaled [0:2];
  integer k;
  reg signed [47:0] acc;
  always @* begin
    acc = 48'sd0;
    for (k = 0; k < 3; k = k + 1) begin
      acc = ($signed(gain_reg[k]) * raw[k]) / FS + $signed(bias_reg[k])
        + $signed(offset_reg[k]);
      scaled[k] = sat(acc);
    end
  end

  // channel enable: mask only acts while an assigned input is closed
  wire [2:0] chan_en_next = (analog_enable_assigned_i & analog_enable_closed_i) ?
    enable_mask_reg : 3'h7;

  // routing: collect each function from the enabled channels
  reg signed [47:0] bias_sum, bias_any_sum, gain_v, pi_fb, pi_diff, stall_v;
  reg has_bias, has_gain, has_aux1, has_aux2, has_vb, has_ramp, has_dc;
  reg has_tq, has_stall, has_low, has_fb, has_sp, has_temp, has_diff;
  reg signed [DW-1:0] aux1_v, aux2_v, vb_v, ramp_v, dc_v, tq_v, low_v, sp_v, temp_v;
  reg signed [47:0] fref_v;
  integer j;
  always @* begin
    bias_sum = 48'sd0;
    bias_any_sum = 48'sd0;
    gain_v = FS;
    pi_fb = 48'sd0;
    pi_diff = 48'sd0;
    stall_v = 48'sd0;
    {has_bias, has_gain, has_aux1, has_aux2, has_vb, has_ramp, has_dc} = 7'h00;
    {has_tq, has_stall, has_low, has_fb, has_sp, has_temp, has_diff} = 7'h00;
    aux1_v = {DW{1'b0}};
    aux2_v = {DW{1'b0}};
    vb_v = {DW{1'b0}};
    ramp_v = {DW{1'b0}};
    dc_v = {DW{1'b0}};
    tq_v = {DW{1'b0}};
    low_v = {DW{1'b0}};
    sp_v = {DW{1'b0}};
    temp_v = {DW{1'b0}};
    for (j = 0; j < 3; j = j + 1) begin
      if (chan_en_reg[j] && known_code(func_reg[j])) begin
        case (func_reg[j])
          `AIR_FN_FREQ_BIAS: begin
            bias_sum = bias_sum + scaled[j];
            has_bias = 1'b1;
          end
          `AIR_FN_FREQ_GAIN: begin
            gain_v = (gain_v * scaled[j]) / FS;
            has_gain = 1'b1;
          end
          `AIR_FN_AUX_REF1: begin
            aux1_v = scaled[j];
            has_aux1 = 1'b1;
          end
          `AIR_FN_AUX_REF2: begin
            aux2_v = scaled[j];
            has_aux2 = 1'b1;
          end
          `AIR_FN_VOLT_BIAS: begin
            vb_v = scaled[j];
            has_vb = ctl_reg[`AIR_CTL_VF_MODE];
          end
          `AIR_FN_RAMP_GAIN: begin
            ramp_v = scaled[j];
            has_ramp = 1'b1;
          end
          `AIR_FN_DC_BRAKE: begin
            dc_v = scaled[j];
            has_dc = 1'b1;
          end
          `AIR_FN_TORQUE_LVL: begin
            tq_v = scaled[j];
            has_tq = 1'b1;
          end
          `AIR_FN_STALL_LVL: begin
            stall_v = scaled[j];
            has_stall = 1'b1;
          end
          `AIR_FN_FREQ_LOWER: begin
            low_v = scaled[j];
            has_low = 1'b1;
          end
          `AIR_FN_PI_FEEDBACK: begin
            pi_fb = pi_fb + scaled[j];
            has_fb = ctl_reg[`AIR_CTL_PI_EN];
          end
          `AIR_FN_PI_SETPOINT: begin
            sp_v = scaled[j];
            has_sp = ctl_reg[`AIR_CTL_PI_EN];
          end
          `AIR_FN_FREQ_BIAS_ANY: begin
            bias_any_sum = bias_any_sum + scaled[j];
          end
          `AIR_FN_MOTOR_TEMP: begin
            if (j == 2) begin
              temp_v = scaled[j];
              has_temp = 1'b1;
            end
          end
          `AIR_FN_PI_DIFF: begin
            pi_diff = pi_diff + scaled[j];
            has_diff = 1'b1;
          end
          default: begin
            // pass-through and reserved codes feed nothing
            has_bias = has_bias;
          end
        endcase
      end
    end
    // frequency reference: analog bias only on an analog source
    if (ctl_reg[`AIR_CTL_REF_ANALOG])
      fref_v = ((freq_ref_i + bias_sum) * (has_gain ? gain_v : FS)) / FS;
    else
      fref_v = freq_ref_i;
    fref_v = fref_v + bias_any_sum;
    // differential feedback: input minus differential channel
    pi_fb = pi_fb - pi_diff;
  end

  // ramp time product, gain in tenths of a percent
  wire [47:0] ramp_prod = ramp_time_settings_i * $unsigned({{(48-DW){1'b0}}, ramp_v});
  // divide before cutting to width, else the high product bits are lost
  wire [47:0] ramp_quot = ramp_prod / FS;

  // registered outputs
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan_en_reg <= 3'h7;
      freq_ref_o <= {DW{1'b0}};
      aux_ref1_o <= {DW{1'b0}};
      aux_ref1_valid_o <= 1'b0;
      aux_ref2_o <= {DW{1'b0}};
      aux_ref2_valid_o <= 1'b0;
      volt_bias_o <= {DW{1'b0}};
      ramp_time_o <= {DW{1'b0}};
      dc_brake_level_o <= {DW{1'b0}};
      dc_brake_valid_o <= 1'b0;
      torque_detect_level_o <= {DW{1'b0}};
      stall_level_o <= {DW{1'b0}};
      freq_lower_o <= {DW{1'b0}};
      freq_lower_valid_o <= 1'b0;
      pi_feedback_o <= {DW{1'b0}};
      pi_feedback_valid_o <= 1'b0;
      pi_setpoint_o <= {DW{1'b0}};
      pi_setpoint_valid_o <= 1'b0;
      motor_temp_o <= {DW{1'b0}};
      motor_temp_valid_o <= 1'b0;
    end else begin
      chan_en_reg <= chan_en_next;
      freq_ref_o <= sat(fref_v);
      aux_ref1_o <= aux1_v;
      aux_ref1_valid_o <= has_aux1;
      aux_ref2_o <= aux2_v;
      aux_ref2_valid_o <= has_aux2;
      volt_bias_o <= has_vb ? vb_v : {DW{1'b0}};
      // ramp times unchanged unless a channel supplies the gain
      ramp_time_o <= has_ramp ? ramp_quot[DW-1:0] : ramp_time_settings_i;
      dc_brake_level_o <= dc_v;
      dc_brake_valid_o <= has_dc;
      torque_detect_level_o <= has_tq ? tq_v : torque_detect_level_i;
      stall_level_o <= (has_stall && (stall_v < running_stall_level_i)) ?
        sat(stall_v) : running_stall_level_i;
      freq_lower_o <= low_v;
      freq_lower_valid_o <= has_low;
      pi_feedback_o <= sat(pi_fb);
      pi_feedback_valid_o <= ctl_reg[`AIR_CTL_PI_EN] & (has_fb | has_diff);
      pi_setpoint_o <= sp_v;
      pi_setpoint_valid_o <= has_sp;
      motor_temp_o <= temp_v;
      motor_temp_valid_o <= has_temp;
    end
  end

  // register writes on the access edge; offsets clamp to range
  integer n;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      enable_mask_reg <= `AIR_RST_ENABLE_MASK;
      func_reg[0] <= `AIR_RST_FUNC_CH1;
      func_reg[1] <= `AIR_RST_FUNC_CH2;
      func_reg[2] <= `AIR_RST_FUNC_CH3;
      ctl_reg <= 3'h4;
      for (n = 0; n < 3; n = n + 1) begin
        offset_reg[n] <= `AIR_RST_OFFSET;
        gain_reg[n] <= `AIR_RST_GAIN;
        bias_reg[n] <= `AIR_RST_BIAS;
        level_reg[n] <= {DW{1'b0}};
      end
    end else begin
      // levels stay readable whatever the code
      for (n = 0; n < 3; n = n + 1)
        level_reg[n] <= scaled[n];
      if (apb_wr && addr_ok) begin
        case (widx)
          4'h0: begin
            // zero is outside the range and ignored
            if (pwdata_i[2:0] != 3'h0)
              enable_mask_reg <= pwdata_i[2:0];
          end
          4'h1: offset_reg[0] <= clamp_offset(pwdata_i[15:0]);
          4'h2: offset_reg[1] <= clamp_offset(pwdata_i[15:0]);
          4'h3: offset_reg[2] <= clamp_offset(pwdata_i[15:0]);
          4'h4: begin
            func_reg[0] <= pwdata_i[5:0];
            func_reg[1] <= pwdata_i[13:8];
            func_reg[2] <= pwdata_i[21:16];
          end
          4'h5: ctl_reg <= pwdata_i[2:0];
          4'h6: gain_reg[0] <= pwdata_i[15:0];
          4'h7: gain_reg[1] <= pwdata_i[15:0];
          4'h8: gain_reg[2] <= pwdata_i[15:0];
          4'h9: bias_reg[0] <= pwdata_i[15:0];
          4'ha: bias_reg[1] <= pwdata_i[15:0];
          4'hb: bias_reg[2] <= pwdata_i[15:0];
          default: ctl_reg <= ctl_reg;
        endcase
      end
    end
  end

  // apb answer: ready in the first access cycle, read data captured at setup
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup & ~addr_ok;
      if (apb_setup) begin
        case (paddr_i[5:2])
          4'h0: prdata_o <= {29'h0, enable_mask_reg};
          4'h1: prdata_o <= {16'h0, offset_reg[0]};
          4'h2: prdata_o <= {16'h0, offset_reg[1]};
          4'h3: prdata_o <= {16'h0, offset_reg[2]};
          4'h4: prdata_o <= {10'h0, func_reg[2], 2'h0, func_reg[1], 2'h0, func_reg[0]};
          4'h5: prdata_o <= {29'h0, ctl_reg};
          4'h6: prdata_o <= {16'h0, gain_reg[0]};
          4'h7: prdata_o <= {16'h0, gain_reg[1]};
          4'h8: prdata_o <= {16'h0, gain_reg[2]};
          4'h9: prdata_o <= {16'h0, bias_reg[0]};
          4'ha: prdata_o <= {16'h0, bias_reg[1]};
          4'hb: prdata_o <= {16'h0, bias_reg[2]};
          4'hc: prdata_o <= {29'h0, chan_en_reg};
          4'hd: prdata_o <= {{(32-DW){level_reg[0][DW-1]}}, level_reg[0]};
          4'he: prdata_o <= {{(32-DW){level_reg[1][DW-1]}}, level_reg[1]};
          4'hf: prdata_o <= {{(32-DW){level_reg[2][DW-1]}}, level_reg[2]};
          default: prdata_o <= 32'h0000_0000;
        endcase
        if (!addr_ok)
          prdata_o <= 32'h0000_0000;
      end
    end
  end

endmodule // air_router

// ==== air_src_model.sv ====
/* analog source model: three conditioned channels and the drive levels.
   assumes the bench asks for new levels by load_i, one 100 MHz clock. */
`timescale 1ns/1ps
module air_src_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [95:0] lvl_i,
  output logic signed [15:0] ch1_o,
  output logic signed [15:0] ch2_o,
  output logic signed [15:0] ch3_o,
  output logic signed [15:0] fref_o,
  output logic signed [15:0] stall_o,
  output logic [15:0] ramp_o
);
  // levels step only on load and hold, like a settled filtered input
  always @(posedge sys_clk_i) begin
    if (!rst_n_i)
      {ch1_o, ch2_o, ch3_o, fref_o, stall_o, ramp_o} <= 96'h0;
    else if (load_i)
      {ch1_o, ch2_o, ch3_o, fref_o, stall_o, ramp_o} <= lvl_i;
  end
endmodule // air_src_model

// ==== air_router_assertions.sv ====
/* checker for air_router: apb answer timing and routing gates.
   assumes binding onto air_router, one clock, synchronous reset. */
`timescale 1ns/1ps
module air_router_chk #(
  parameter DW = 16
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire signed [DW-1:0] running_stall_level_i,
  input wire [DW-1:0] ramp_time_settings_i,
  input wire [DW-1:0] ramp_time_o,
  input wire signed [DW-1:0] stall_level_o,
  input wire signed [DW-1:0] volt_bias_o,
  input wire aux_ref1_valid_o,
  input wire dc_brake_valid_o,
  input wire freq_lower_valid_o,
  input wire pi_setpoint_valid_o,
  input wire motor_temp_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  reg [5:0] c1_reg;
  reg [5:0] c2_reg;
  reg [5:0] c3_reg;
  reg [2:0] ctl_reg;
  reg [8:0] seen_reg;
  wire wr_done = psel_i & penable_i & pwrite_i & pready_o;
  wire [8:0] seen_next;
  function automatic logic has(input logic [5:0] c);
    has = (c1_reg == c) || (c2_reg == c) || (c3_reg == c);
  endfunction
  // outputs lag register values one edge, so gates are delayed too
  assign seen_next = {has(6'h02), has(6'h05), has(6'h06), has(6'h09), has(6'h0c),
                      c3_reg == 6'h0e, ctl_reg};
  // shadow of code and control registers, updated at the completing edge
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      c1_reg <= 6'h00;
      c2_reg <= 6'h00;
      c3_reg <= 6'h02;
      ctl_reg <= 3'h4;
      seen_reg <= 9'h104;
    end else begin
      seen_reg <= seen_next;
      if (wr_done && paddr_i == 12'h010) begin
        c1_reg <= pwdata_i[5:0];
        c2_reg <= pwdata_i[13:8];
        c3_reg <= pwdata_i[21:16];
      end
      if (wr_done && paddr_i == 12'h014)
        ctl_reg <= pwdata_i[2:0];
    end
  end
  chk_ready_one_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("apb answer not a single pulse after setup");
  chk_err_bad_addr: assert property (psel_i && !penable_i && !pwrite_i && paddr_i > 12'h03c
    |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped read not refused");
  chk_stall_lower_of: assert property (stall_level_o <= $past(running_stall_level_i))
    else $error("stall level above programmed level");
  chk_ramp_plain: assert property ($past(rst_n_i) && !seen_reg[7]
    |-> ramp_time_o == $past(ramp_time_settings_i)) else $error("ramp changed without code");
  chk_volt_needs_vf: assert property (!seen_reg[1] |-> volt_bias_o == 16'sd0)
    else $error("voltage bias outside v/f mode");
  chk_aux_needs_code: assert property (aux_ref1_valid_o |-> seen_reg[8])
    else $error("aux reference without its code");
  chk_brake_needs_code: assert property (dc_brake_valid_o |-> seen_reg[6])
    else $error("brake level without its code");
  chk_lower_needs_code: assert property (freq_lower_valid_o |-> seen_reg[5])
    else $error("lower limit without its code");
  chk_set_needs_pi: assert property (pi_setpoint_valid_o |-> seen_reg[4] && seen_reg[0])
    else $error("setpoint without code or pi enable");
  chk_temp_third_only: assert property (motor_temp_valid_o |-> seen_reg[3])
    else $error("motor temperature not from third channel");
endmodule // air_router_chk

bind air_router air_router_chk #(.DW(DW)) i_air_router_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .running_stall_level_i(running_stall_level_i),
  .ramp_time_settings_i(ramp_time_settings_i), .ramp_time_o(ramp_time_o),
  .stall_level_o(stall_level_o), .volt_bias_o(volt_bias_o),
  .aux_ref1_valid_o(aux_ref1_valid_o), .dc_brake_valid_o(dc_brake_valid_o),
  .freq_lower_valid_o(freq_lower_valid_o), .pi_setpoint_valid_o(pi_setpoint_valid_o),
  .motor_temp_valid_o(motor_temp_valid_o));

// ==== testbench.sv ====
/* bench for air_router: register reset values, mask gating, offsets, code sweep.
   assumes air_src_model drives the analog side, one 100 MHz clock. */
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, seed = 32'h000160c7;
  logic pready_o, pslverr_o, er, ena = 0, cls = 0, ld = 0;
  logic [95:0] lvl = 96'h0;
  logic signed [15:0] c1, c2, c3, fr, st, fo, a1, a2, vb, db, tq, so, fl, pf, ps, mt;
  logic [15:0] rt, ro;
  logic v1, v2, vd, vl, vf, vs, vm;
  int n_fail = 0, num_checks = 0;
  logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h024};
  logic [31:0] rv [8] = '{32'h7, 32'h0, 32'h0, 32'h0, 32'h20000, 32'h4, 32'h3e8, 32'h0};
  logic [5:0] cl [18] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
                          6'h09, 6'h0b, 6'h0c, 6'h0d, 6'h0f, 6'h17, 6'h30, 6'h1f, 6'h32};
  air_src_model i_air_src_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .load_i(ld),
    .lvl_i(lvl), .ch1_o(c1), .ch2_o(c2), .ch3_o(c3), .fref_o(fr), .stall_o(st), .ramp_o(rt));
  air_router i_air_router (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .first_analog_channel_i(c1), .second_analog_channel_i(c2), .third_analog_channel_i(c3),
    .analog_enable_assigned_i(ena), .analog_enable_closed_i(cls), .analog_freq_ref_i(fr),
    .freq_ref_i(fr), .running_stall_level_i(st), .torque_detect_level_i(st),
    .ramp_time_settings_i(rt), .freq_ref_o(fo), .aux_ref1_o(a1), .aux_ref1_valid_o(v1),
    .aux_ref2_o(a2), .aux_ref2_valid_o(v2), .volt_bias_o(vb), .ramp_time_o(ro),
    .dc_brake_level_o(db), .dc_brake_valid_o(vd), .torque_detect_level_o(tq),
    .stall_level_o(so), .freq_lower_o(fl), .freq_lower_valid_o(vl), .pi_feedback_o(pf),
    .pi_feedback_valid_o(vf), .pi_setpoint_o(ps), .pi_setpoint_valid_o(vs),
    .motor_temp_o(mt), .motor_temp_valid_o(vm));
  // free-running 100 MHz clock
  initial forever #5 sys_clk_i = ~sys_clk_i;
  function logic [15:0] r16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed % 1000;
  endfunction
  // expected routed value per code, ch2 and ch3 parked in through mode
  function automatic int ex(input logic [5:0] c);
    case (c)
      6'h00, 6'h0d: return fr + c1;
      6'h01: return fr * c1 / 1000;
      6'h05: return rt * c1 / 1000;
      6'h08: return (c1 < st) ? c1 : st;
      6'h0f, 6'h17, 6'h30, 6'h1f, 6'h32: return fr;
      default: return c1;
    endcase
  endfunction
  function automatic logic [31:0] ob(input logic [5:0] c);
    case (c)
      6'h02: return a1;
      6'h03: return a2;
      6'h04: return vb;
      6'h05: return ro;
      6'h06: return db;
      6'h07: return tq;
      6'h08: return so;
      6'h09: return fl;
      6'h0b: return pf;
      6'h0c: return ps;
      default: return fo;
    endcase
  endfunction
  // through codes must leave every valid flag low
  function automatic logic vo(input logic [5:0] c);
    case (c)
      6'h02: return v1;
      6'h03: return v2;
      6'h06: return vd;
      6'h09: return vl;
      6'h0b: return vf;
      6'h0c: return vs;
      6'h0f, 6'h17, 6'h30, 6'h1f, 6'h32: return ~|{v1, v2, vd, vl, vf, vs, vm};
      default: return 1'b1;
    endcase
  endfunction
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      give_verdict();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // fresh random levels, then let the two-stage path settle
  task automatic newlv();
    @(posedge sys_clk_i);
    lvl <= {r16(), r16(), r16(), r16(), r16(), r16()};
    ld <= 1'b1;
    @(posedge sys_clk_i);
    ld <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic cfg(input logic [31:0] codes, input logic [31:0] ctl);
    apb(1'b1, 12'h010, codes);
    apb(1'b1, 12'h014, ctl);
    newlv();
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_fail++;
    give_verdict();
  end
  initial begin
    int m;
    int i;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped err", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    ena <= 1'b1;
    cls <= 1'b1;
    for (m = 1; m < 8; m++) begin
      apb(1'b1, 12'h000, m);
      newlv();
      apb(1'b0, 12'h030, 32'h0);
      chk("status", rd, m);
      chk("masked sum", fo, fr + (m[0] ? c1 : 0) + (m[1] ? c2 : 0));
      chk("aux gated", v1, m[2]);
    end
    apb(1'b1, 12'h000, 32'h1);
    ena <= 1'b0;
    newlv();
    apb(1'b0, 12'h030, 32'h0);
    chk("all enabled", rd, 32'h7);
    chk("full sum", fo, fr + c1 + c2);
    apb(1'b1, 12'h004, 32'h258);
    apb(1'b0, 12'h004, 32'h0);
    chk("clamp high", rd, 32'h1f4);
    apb(1'b1, 12'h008, 32'hfffffda8);
    apb(1'b0, 12'h008, 32'h0);
    chk("clamp low", rd, 32'h0000fe0c);
    apb(1'b1, 12'h008, 32'hffffffe2);
    newlv();
    chk("offset sum", fo, fr + c1 + 500 + c2 - 30);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    for (i = 0; i < 18; i++) begin
      cfg(32'h000f0f00 | cl[i], 32'h7);
      chk("route", ob(cl[i]), ex(cl[i]));
      chk("valid", vo(cl[i]), 1'b1);
    end
    cfg(32'h000f0f00, 32'h3);
    chk("bias ignored", fo, fr);
    cfg(32'h000f0f0d, 32'h3);
    chk("bias any", fo, fr + c1);
    cfg(32'h000f0f0b, 32'h4);
    chk("pi off", vf, 1'b0);
    cfg(32'h000f0f04, 32'h4);
    chk("vf off", vb, 32'h0);
    cfg(32'h000f160b, 32'h7);
    chk("pi diff", pf, c1 - c2);
    cfg(32'h000e0f0e, 32'h7);
    chk("temp", {vm, mt}, {1'b1, c3});
    cfg(32'h000f0f0e, 32'h7);
    chk("temp ch1", vm, 1'b0);
    give_verdict();
  end
endmodule // testbench
